/* File: rtl/dfrs_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - keep last five trips, browsable one by one
// - commit pending trip to history on reset
// - entry holds type, frequency, current, ramp state
// - twelve distinct fault type codes
// - hardware fault never cleared by reset
// - report only highest priority active fault
// - erase command clears whole history at once
// - zero dwell duration skips dwell step
// - three jump bands snap to band edge
// - jump bands only at steady speed
// - two-bit field enables output/input phase loss
// - no autostart: toggle run after power-up
// - autostart: run resumes at power-up
// - reset restart option or run toggle
// - four-bit speed search enable per event
// - search current limited to percent of rated
// - separate search proportional and integral gains
// - auto clear and restart up to count
// - no auto restart for undervoltage, halt, hardware
// - retry count down per fault, up after 30s
module dfrs_supervisor
  import dfrs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int CREDIT_TICKS = CREDIT_TICKS_DEF,
  parameter int HIST_DEPTH = HIST_DEPTH_DEF
)(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // terminal pins, asynchronous
  input wire logic [NFAULT-1:0] fault_in,
  input wire logic forward_run_input,
  input wire logic reverse_run_input,
  input wire logic reset_terminal,
  input wire logic power_dip,
  // output stage status, same clock
  input wire logic [FREQ_W-1:0] ref_freq,
  input wire logic [CUR_W-1:0] out_current,
  input wire logic [1:0] ramp_state,
  input wire logic speed_locked,
  // output stage commands
  output logic run_out,
  output logic [FREQ_W-1:0] freq_cmd,
  output logic dwell_active,
  output logic search_active,
  output logic [23:0] search_current_limit,
  output logic [7:0] speed_search_p_gain,
  output logic [7:0] speed_search_i_gain,
  output logic tripped,
  output logic [3:0] fault_code,
  output logic [3:0] retry_left
);

  // highest priority: hardware first, then lowest code
  function automatic logic [3:0] dfrs_prio(input logic [NFAULT-1:0] v);
    logic [3:0] c;
    c = FLT_NONE;
    for (int i = NFAULT - 1; i >= 0; i--)
    begin
      if (v[i])
        c = 4'(i + 1);
    end
    if (v[FLT_HARDWARE - 4'h1])
      c = FLT_HARDWARE;
    return c;
  endfunction : dfrs_prio

  // reference inside [lo,hi] snaps to the lower edge
  function automatic logic [FREQ_W-1:0] dfrs_jump(input logic [FREQ_W-1:0] f,
                                                  input logic [31:0] band);
    logic in_band;
    in_band = (f >= band[15:0]) && (f <= band[31:16]);
    return in_band ? band[15:0] : f;
  endfunction : dfrs_jump

  // two-flop synchronisers for all pins
  localparam int SYNC_W = NFAULT + 4;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic rst_term_prev_ff;

  // configuration registers
  logic [7:0] ctrl_ff;
  logic [31:0] dwell_ff;
  logic [31:0] jump_ff [3];
  logic [23:0] search_ff;
  logic [15:0] rated_current_ff;
  logic [3:0] retry_cfg_ff;
  logic [15:0] retry_delay_ff;
  logic [2:0] hist_sel_ff;

  // supervisor state
  dfrs_state_t state_ff;
  dfrs_state_t nxt_state;
  logic [15:0] tick_cnt_ff;
  logic [15:0] timer_ff;
  logic [15:0] credit_ff;
  logic fresh_ff;
  logic armed_ff;
  logic ipf_ff;
  logic restarted_ff;
  logic hw_latched_ff;
  logic [3:0] pend_code_ff;
  logic [FREQ_W-1:0] pend_freq_ff;
  logic [CUR_W-1:0] pend_cur_ff;
  logic [1:0] pend_ramp_ff;

  // history storage, slot 0 is the newest
  logic [3:0] hist_type_ff [HIST_DEPTH];
  logic [FREQ_W-1:0] hist_freq_ff [HIST_DEPTH];
  logic [CUR_W-1:0] hist_cur_ff [HIST_DEPTH];
  logic [1:0] hist_ramp_ff [HIST_DEPTH];
  logic [2:0] hist_cnt_ff;

  // output flops
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic run_ff;
  logic [FREQ_W-1:0] freq_ff;
  logic search_ff_on;
  logic [23:0] limit_ff;
  logic tripped_ff;
  logic [3:0] fault_code_ff;
  logic [3:0] retry_left_ff;

  // synchronised pin views
  wire logic [NFAULT-1:0] flt_s = sync2_ff[NFAULT-1:0];
  wire logic fwd_s = sync2_ff[NFAULT];
  wire logic rev_s = sync2_ff[NFAULT+1];
  wire logic rst_term_s = sync2_ff[NFAULT+2];
  wire logic dip_s = sync2_ff[NFAULT+3];
  wire logic run_cmd = fwd_s | rev_s;

  // fault masking and priority
  wire logic [1:0] phase_sel = ctrl_ff[1:0];
  wire logic [NFAULT-1:0] flt_en = {1'b1, phase_sel[1], phase_sel[0], 9'h1FF};
  wire logic [NFAULT-1:0] flt_act = flt_s & flt_en;
  wire logic [3:0] top_code = dfrs_prio(flt_act);
  wire logic in_trip = (state_ff == ST_TRIP) || (state_ff == ST_RETRY_WAIT);
  wire logic trip_new = !in_trip && (top_code != FLT_NONE);

  // auto restart eligibility
  wire logic no_retry_type = (top_code == FLT_UNDERVOLTAGE) ||
                             (top_code == FLT_EMERGENCY_HALT) ||
                             (top_code == FLT_HARDWARE);
  wire logic retry_ok = !no_retry_type && (retry_left_ff != 4'h0);
  wire dfrs_state_t trip_dest = retry_ok ? ST_RETRY_WAIT : ST_TRIP;

  // apb decode
  wire logic apb_take = psel && penable && pready_ff;
  wire logic apb_wr = apb_take && pwrite;
  wire logic sel_ctrl = (paddr == ADDR_CTRL);
  wire logic sel_dwell = (paddr == ADDR_DWELL);
  wire logic sel_j0 = (paddr == ADDR_JUMP0);
  wire logic sel_j1 = (paddr == ADDR_JUMP1);
  wire logic sel_j2 = (paddr == ADDR_JUMP2);
  wire logic sel_search = (paddr == ADDR_SEARCH);
  wire logic sel_motor = (paddr == ADDR_MOTOR);
  wire logic sel_retry = (paddr == ADDR_RETRY);
  wire logic sel_status = (paddr == ADDR_STATUS);
  wire logic sel_hsel = (paddr == ADDR_HIST_SEL);
  wire logic sel_ha = (paddr == ADDR_HIST_A);
  wire logic sel_hb = (paddr == ADDR_HIST_B);
  wire logic sel_cmd = (paddr == ADDR_CMD);
  wire logic mapped = sel_ctrl | sel_dwell | sel_j0 | sel_j1 | sel_j2 | sel_search |
                      sel_motor | sel_retry | sel_status | sel_hsel | sel_ha |
                      sel_hb | sel_cmd;
  wire logic erase_cmd = apb_wr && sel_cmd && pwdata[CMD_ERASE_BIT];
  wire logic key_reset = apb_wr && sel_cmd && pwdata[CMD_KEY_RESET_BIT];

  // history entry under browse, empty slots read zero
  wire logic hsel_ok = ({1'b0, hist_sel_ff} < {1'b0, hist_cnt_ff});
  wire logic [31:0] hist_a = hsel_ok ? {hist_freq_ff[hist_sel_ff], 10'h000,
                                        hist_ramp_ff[hist_sel_ff],
                                        hist_type_ff[hist_sel_ff]} : 32'h0000_0000;
  wire logic [31:0] hist_b = hsel_ok ? {16'h0000, hist_cur_ff[hist_sel_ff]} : 32'h0000_0000;
  wire logic [31:0] status_word = {13'h0000, state_ff, hw_latched_ff, hist_cnt_ff,
                                   retry_left_ff, search_ff_on, dwell_active, run_ff,
                                   tripped_ff, fault_code_ff};
  wire logic [31:0] rd_mux =
    sel_ctrl ? {24'h00_0000, ctrl_ff} :
    sel_dwell ? dwell_ff :
    sel_j0 ? jump_ff[0] :
    sel_j1 ? jump_ff[1] :
    sel_j2 ? jump_ff[2] :
    sel_search ? {8'h00, search_ff} :
    sel_motor ? {16'h0000, rated_current_ff} :
    sel_retry ? {retry_delay_ff, 12'h000, retry_cfg_ff} :
    sel_status ? status_word :
    sel_hsel ? {29'h0000_0000, hist_sel_ff} :
    sel_ha ? hist_a :
    sel_hb ? hist_b : 32'h0000_0000;

  // fault clearing sources
  wire logic manual_reset = (key_reset || (rst_term_s && !rst_term_prev_ff)) &&
                            !hw_latched_ff;
  wire logic halt_release = (pend_code_ff == FLT_EMERGENCY_HALT) &&
                            !flt_s[FLT_EMERGENCY_HALT - 4'h1];
  wire logic tick = (tick_cnt_ff == 16'(TICK_CYCLES - 1));
  wire logic [15:0] dwell_dur = dwell_ff[31:16];
  wire logic dwell_on = (dwell_dur != 16'h0000);
  wire logic dwell_done = timer_ff >= dwell_dur;
  wire logic delay_done = timer_ff >= retry_delay_ff;
  wire logic autostart = ctrl_ff[CTRL_AUTOSTART_BIT];
  wire logic reset_restart = ctrl_ff[CTRL_RESET_RESTART_BIT];
  wire logic [3:0] ss_sel = ctrl_ff[CTRL_SEARCH_LSB +: 4];
  wire logic start_ok = run_cmd && !dip_s && (armed_ff || (fresh_ff && autostart));
  wire logic credit_done = (credit_ff == 16'(CREDIT_TICKS - 1)) && tick;

  // state transitions and start decisions
  logic go_start;
  logic want_search;
  logic clr_fault;
  always_comb
  begin
    nxt_state = state_ff;
    go_start = 1'b0;
    want_search = 1'b0;
    clr_fault = 1'b0;
    case (state_ff)
      ST_STOP:
        if (trip_new)
          nxt_state = trip_dest;
        else if (ipf_ff && run_cmd && !dip_s)
        begin
          go_start = 1'b1;
          want_search = ss_sel[SS_POWER_DIP];
        end
        else if (start_ok)
        begin
          go_start = 1'b1;
          want_search = fresh_ff ? ss_sel[SS_POWER_ON] : ss_sel[SS_ACCEL];
        end
      ST_DWELL:
        if (trip_new)
          nxt_state = trip_dest;
        else if (!run_cmd)
          nxt_state = ST_STOP;
        else if (dwell_done)
          nxt_state = ST_RUN;
      ST_RUN:
        if (trip_new)
          nxt_state = trip_dest;
        else if (!run_cmd || dip_s)
          nxt_state = ST_STOP;
      ST_TRIP, ST_RETRY_WAIT:
        if (manual_reset || halt_release)
        begin
          clr_fault = 1'b1;
          nxt_state = ST_STOP;
          if (reset_restart && run_cmd && manual_reset)
          begin
            go_start = 1'b1;
            want_search = ss_sel[SS_RESTART];
          end
        end
        else if (state_ff == ST_RETRY_WAIT && delay_done)
        begin
          clr_fault = 1'b1;
          nxt_state = ST_STOP;
          go_start = run_cmd;
          want_search = ss_sel[SS_RESTART];
        end
      default:
        nxt_state = ST_STOP;
    endcase
    if (go_start)
      nxt_state = dwell_on ? ST_DWELL : ST_RUN;
  end

  // output frequency: dwell value, banded reference or plain sweep
  wire logic [FREQ_W-1:0] jf0 = dfrs_jump(ref_freq, jump_ff[0]);
  wire logic [FREQ_W-1:0] jf1 = dfrs_jump(jf0, jump_ff[1]);
  wire logic [FREQ_W-1:0] jf2 = dfrs_jump(jf1, jump_ff[2]);
  wire logic [FREQ_W-1:0] run_freq = (ramp_state == RAMP_STEADY) ? jf2 : ref_freq;
  wire logic [FREQ_W-1:0] nxt_freq = (nxt_state == ST_DWELL) ? dwell_ff[15:0] :
                                     (nxt_state == ST_RUN) ? run_freq : 16'h0000;
  wire logic [23:0] nxt_limit = 24'(({8'h00, rated_current_ff} * {16'h0000, search_ff[7:0]})
                                    / PERCENT_DIV);

  // pins pass two flops before use
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff <= {4'h3, {NFAULT{1'b0}}}; // no false run drop at power-up
      sync2_ff <= {4'h3, {NFAULT{1'b0}}};
      rst_term_prev_ff <= 1'b0;
    end
    else if (ce)
    begin
      sync1_ff <= {power_dip, reset_terminal, reverse_run_input, forward_run_input, fault_in};
      sync2_ff <= sync1_ff;
      rst_term_prev_ff <= rst_term_s;
    end
  end

  // apb slave: one wait state, then pready for one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !mapped;
      prdata_ff <= (psel && penable && !pready_ff && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // configuration writes take effect on the accepting edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= CTRL_RST;
      dwell_ff <= DWELL_RST;
      for (int i = 0; i < 3; i++)
        jump_ff[i] <= JUMP_RST;
      search_ff <= SEARCH_RST;
      rated_current_ff <= MOTOR_RST;
      retry_cfg_ff <= RETRY_COUNT_RST;
      retry_delay_ff <= RETRY_DELAY_RST;
      hist_sel_ff <= 3'h0;
    end
    else if (ce && apb_wr)
    begin
      if (sel_ctrl) ctrl_ff <= pwdata[7:0];
      if (sel_dwell) dwell_ff <= pwdata;
      if (sel_j0) jump_ff[0] <= pwdata;
      if (sel_j1) jump_ff[1] <= pwdata;
      if (sel_j2) jump_ff[2] <= pwdata;
      if (sel_search) search_ff <= pwdata[23:0];
      if (sel_motor) rated_current_ff <= pwdata[15:0];
      if (sel_retry) retry_cfg_ff <= pwdata[3:0];
      if (sel_retry) retry_delay_ff <= pwdata[31:16];
      if (sel_hsel) hist_sel_ff <= pwdata[2:0];
    end
  end

  // millisecond time base and state timer, restarted on every state change
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_ff <= 16'h0000;
      timer_ff <= 16'h0000;
    end
    else if (ce)
    begin
      tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
      if (nxt_state != state_ff)
        timer_ff <= 16'h0000;
      else if (tick && timer_ff != 16'hFFFF)
        timer_ff <= timer_ff + 16'h0001;
    end
  end

  // run control: power-up, arming by run toggle, power dip memory
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_STOP;
      fresh_ff <= 1'b1;
      armed_ff <= 1'b0;
      ipf_ff <= 1'b0;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
      if (go_start || !run_cmd)
        fresh_ff <= 1'b0;
      if (!run_cmd)
        armed_ff <= 1'b1;
      else if (clr_fault && !go_start)
        armed_ff <= 1'b0;
      if (state_ff == ST_RUN && dip_s && run_cmd)
        ipf_ff <= 1'b1;
      else if (go_start || !run_cmd || trip_new)
        ipf_ff <= 1'b0;
    end
  end

  // trip capture; a hardware trip stays until power cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hw_latched_ff <= 1'b0;
      pend_code_ff <= FLT_NONE;
      pend_freq_ff <= 16'h0000;
      pend_cur_ff <= 16'h0000;
      pend_ramp_ff <= RAMP_STEADY;
    end
    else if (ce)
    begin
      if (trip_new)
      begin
        pend_code_ff <= top_code;
        pend_freq_ff <= freq_ff;
        pend_cur_ff <= out_current;
        pend_ramp_ff <= ramp_state;
        if (top_code == FLT_HARDWARE)
          hw_latched_ff <= 1'b1;
      end
      else if (clr_fault)
        pend_code_ff <= FLT_NONE;
    end
  end

  // history: commit on clear, oldest falls off the end; erase wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist_cnt_ff <= 3'h0;
      for (int i = 0; i < HIST_DEPTH; i++)
      begin
        hist_type_ff[i] <= FLT_NONE;
        hist_freq_ff[i] <= 16'h0000;
        hist_cur_ff[i] <= 16'h0000;
        hist_ramp_ff[i] <= RAMP_STEADY;
      end
    end
    else if (ce)
    begin
      if (erase_cmd)
      begin
        hist_cnt_ff <= 3'h0;
        for (int i = 0; i < HIST_DEPTH; i++)
          hist_type_ff[i] <= FLT_NONE;
      end
      else if (clr_fault)
      begin
        for (int i = HIST_DEPTH - 1; i > 0; i--)
        begin
          hist_type_ff[i] <= hist_type_ff[i-1];
          hist_freq_ff[i] <= hist_freq_ff[i-1];
          hist_cur_ff[i] <= hist_cur_ff[i-1];
          hist_ramp_ff[i] <= hist_ramp_ff[i-1];
        end
        hist_type_ff[0] <= pend_code_ff;
        hist_freq_ff[0] <= pend_freq_ff;
        hist_cur_ff[0] <= pend_cur_ff;
        hist_ramp_ff[0] <= pend_ramp_ff;
        if (hist_cnt_ff != 3'(HIST_DEPTH))
          hist_cnt_ff <= hist_cnt_ff + 3'h1;
      end
    end
  end

  // retry budget: spent per fault, earned back by a clean run after restart
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      retry_left_ff <= RETRY_COUNT_RST;
      credit_ff <= 16'h0000;
      restarted_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (apb_wr && sel_retry)
        retry_left_ff <= pwdata[3:0];
      else if (trip_new && retry_left_ff != 4'h0)
        retry_left_ff <= retry_left_ff - 4'h1;
      else if (restarted_ff && credit_done && retry_left_ff < retry_cfg_ff)
        retry_left_ff <= retry_left_ff + 4'h1;
      if (clr_fault && go_start)
        restarted_ff <= 1'b1;
      else if (trip_new || credit_done || nxt_state == ST_STOP)
        restarted_ff <= 1'b0;
      if (state_ff != ST_RUN || !restarted_ff || credit_done)
        credit_ff <= 16'h0000;
      else if (tick)
        credit_ff <= credit_ff + 16'h0001;
    end
  end

  // registered outputs to the output stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_ff <= 1'b0;
      freq_ff <= 16'h0000;
      search_ff_on <= 1'b0;
      limit_ff <= 24'h00_0000;
      tripped_ff <= 1'b0;
      fault_code_ff <= FLT_NONE;
    end
    else if (ce)
    begin
      run_ff <= (nxt_state == ST_DWELL) || (nxt_state == ST_RUN);
      freq_ff <= nxt_freq;
      if (go_start)
        search_ff_on <= want_search;
      else if (speed_locked || !((nxt_state == ST_DWELL) || (nxt_state == ST_RUN)))
        search_ff_on <= 1'b0;
      limit_ff <= nxt_limit;
      tripped_ff <= (nxt_state == ST_TRIP) || (nxt_state == ST_RETRY_WAIT);
      fault_code_ff <= trip_new ? top_code : (clr_fault ? FLT_NONE : pend_code_ff);
    end
  end

  // a hardware trip keeps its code until power is removed
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign run_out = run_ff;
  assign freq_cmd = freq_ff;
  assign dwell_active = run_ff && (state_ff == ST_DWELL);
  assign search_active = search_ff_on;
  assign search_current_limit = limit_ff;
  assign speed_search_p_gain = search_ff[15:8];
  assign speed_search_i_gain = search_ff[23:16];
  assign tripped = tripped_ff;
  assign fault_code = fault_code_ff;
  assign retry_left = retry_left_ff;

endmodule : dfrs_supervisor
`default_nettype wire

/* File: include/dfrs_pkg.sv */
package dfrs_pkg;
  // clock and time base
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES_DEF = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
  localparam int CREDIT_TIME_S = 30;
  localparam int CREDIT_TICKS_DEF = CREDIT_TIME_S * 1000 / TICK_PERIOD_MS;
  // history depth and field widths
  localparam int HIST_DEPTH_DEF = 5;
  localparam int FREQ_W = 16;
  localparam int CUR_W = 16;
  localparam int NFAULT = 12;
  // fault type codes, zero means no fault
  localparam logic [3:0] FLT_NONE = 4'h0;
  localparam logic [3:0] FLT_OVERCURRENT = 4'h1;
  localparam logic [3:0] FLT_HIGH_DC_BUS = 4'h2;
  localparam logic [3:0] FLT_EMERGENCY_HALT = 4'h3;
  localparam logic [3:0] FLT_UNDERVOLTAGE = 4'h4;
  localparam logic [3:0] FLT_EARTH_LEAK = 4'h5;
  localparam logic [3:0] FLT_HEATSINK_HOT = 4'h6;
  localparam logic [3:0] FLT_MOTOR_I2T = 4'h7;
  localparam logic [3:0] FLT_LOAD_EXCESS = 4'h8;
  localparam logic [3:0] FLT_HARDWARE = 4'h9;
  localparam logic [3:0] FLT_OUT_PHASE = 4'hA;
  localparam logic [3:0] FLT_IN_PHASE = 4'hB;
  localparam logic [3:0] FLT_DRIVE_OVERLOAD = 4'hC;
  // ramp state reported by the frequency generator
  localparam logic [1:0] RAMP_STEADY = 2'h0;
  localparam logic [1:0] RAMP_ACCEL = 2'h1;
  localparam logic [1:0] RAMP_DECEL = 2'h2;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DWELL = 8'h04;
  localparam logic [7:0] ADDR_JUMP0 = 8'h08;
  localparam logic [7:0] ADDR_JUMP1 = 8'h0C;
  localparam logic [7:0] ADDR_JUMP2 = 8'h10;
  localparam logic [7:0] ADDR_SEARCH = 8'h14;
  localparam logic [7:0] ADDR_MOTOR = 8'h18;
  localparam logic [7:0] ADDR_RETRY = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_HIST_SEL = 8'h24;
  localparam logic [7:0] ADDR_HIST_A = 8'h28;
  localparam logic [7:0] ADDR_HIST_B = 8'h2C;
  localparam logic [7:0] ADDR_CMD = 8'h30;
  // field positions
  localparam int CTRL_AUTOSTART_BIT = 2;
  localparam int CTRL_RESET_RESTART_BIT = 3;
  localparam int CTRL_SEARCH_LSB = 4;
  localparam int CMD_ERASE_BIT = 0;
  localparam int CMD_KEY_RESET_BIT = 1;
  localparam int SS_ACCEL = 0;
  localparam int SS_RESTART = 1;
  localparam int SS_POWER_DIP = 2;
  localparam int SS_POWER_ON = 3;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] DWELL_RST = 32'h0000_0000;
  localparam logic [31:0] JUMP_RST = 32'h0000_0000;
  localparam logic [23:0] SEARCH_RST = 24'h00_0064;
  localparam logic [15:0] MOTOR_RST = 16'h0000;
  localparam logic [3:0] RETRY_COUNT_RST = 4'h0;
  localparam logic [15:0] RETRY_DELAY_RST = 16'h0000;
  localparam logic [23:0] PERCENT_DIV = 24'h00_0064;
  // supervisor states
  typedef enum logic [2:0] {
    ST_STOP = 3'b000,
    ST_DWELL = 3'b001,
    ST_RUN = 3'b010,
    ST_TRIP = 3'b011,
    ST_RETRY_WAIT = 3'b100
  } dfrs_state_t;
endpackage : dfrs_pkg

/* File: sim/dfrs_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module dfrs_properties
  import dfrs_pkg::*;
(
  // bus side
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // output stage side
  input wire logic run_out,
  input wire logic dwell_active,
  input wire logic tripped,
  input wire logic [3:0] fault_code,
  input wire logic [15:0] freq_cmd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // bus answers after exactly one wait state, as a single pulse
  a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_quiet_data: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  // a trip stops the output and always names a cause
  a_trip_halts: assert property (tripped |-> !run_out && freq_cmd == 16'h0000)
    else $error("output live while tripped");
  a_trip_code: assert property (tripped |-> fault_code != FLT_NONE)
    else $error("trip without code");
  a_hw_holds: assert property (tripped && fault_code == FLT_HARDWARE |=>
    tripped && fault_code == FLT_HARDWARE) else $error("hardware trip released");
  a_dwell_runs: assert property (dwell_active |-> run_out) else $error("dwell idle");
endmodule : dfrs_properties
bind dfrs_supervisor dfrs_properties dfrs_properties_i (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .run_out(run_out),
  .dwell_active(dwell_active), .tripped(tripped), .fault_code(fault_code), .freq_cmd(freq_cmd));
`default_nettype wire

/* File: sim/dfrs_motor_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dfrs_motor_model
  import dfrs_pkg::*;
(
  // drive commands
  input wire logic clk,
  input wire logic run_out,
  input wire logic search_active,
  input wire logic [FREQ_W-1:0] freq_cmd,
  input wire logic [23:0] search_current_limit,
  // motor feedback
  output logic [CUR_W-1:0] out_current = '0,
  output logic speed_locked = 1'b0
);
  // current follows speed; lock lags a search by one cycle so the drive must wait
  always @(posedge clk)
  begin
    out_current <= !run_out ? '0 : search_active ? search_current_limit[15:0] : freq_cmd;
    speed_locked <= search_active;
  end
endmodule : dfrs_motor_model
`default_nettype wire

/* File: sim/dfrs_supervisor_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module dfrs_supervisor_tb
  import dfrs_pkg::*;
  ;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, fwd = 0, rerr, rterm = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat, prdata;
  logic [11:0] fault_in = 12'h000;
  logic [15:0] ref_freq = 16'h0000, freq_cmd, out_current;
  logic [1:0] ramp_state = 2'h0;
  logic pready, pslverr, run_out, dwell_active, search_active, tripped, speed_locked;
  logic [23:0] lim;
  logic [3:0] fault_code, retry_left;
  int n_fail = 0, check_count = 0, tcnt = 0;
  int codes[5] = '{5, 6, 7, 8, 10};
  initial forever #10 clk = ~clk;
  // short ms tick and credit keep the run brief
  dfrs_supervisor #(.TICK_CYCLES(10), .CREDIT_TICKS(5)) dfrs_supervisor_i (.clk(clk),
    .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_in(fault_in),
    .forward_run_input(fwd), .reverse_run_input(1'b0), .reset_terminal(rterm),
    .power_dip(1'b0), .ref_freq(ref_freq), .out_current(out_current), .ramp_state(ramp_state),
    .speed_locked(speed_locked), .run_out(run_out), .freq_cmd(freq_cmd),
    .dwell_active(dwell_active), .search_active(search_active), .search_current_limit(lim),
    .speed_search_p_gain(), .speed_search_i_gain(), .tripped(tripped),
    .fault_code(fault_code), .retry_left(retry_left));
  dfrs_motor_model dfrs_motor_model_i (.clk(clk), .run_out(run_out),
    .search_active(search_active), .freq_cmd(freq_cmd), .search_current_limit(lim),
    .out_current(out_current), .speed_locked(speed_locked));
  task close_out;
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task ck(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : ck
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one bus transfer; request held until ready is seen at an edge
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    {rerr, rdat} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask : xf
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    xf(1'b0, a, 32'h0);
    ck(n, e, rdat & m);
  endtask : rd
  task trip(input int b);
    @(posedge clk) fault_in <= 12'h001 << b;
    cyc(6);
    fault_in <= 12'h000;
  endtask : trip
  // operator drops and reapplies the run terminal
  task rerun;
    @(posedge clk) fwd <= 1'b0;
    cyc(4);
    fwd <= 1'b1;
    cyc(6);
  endtask : rerun
  // hang guard
  always @(posedge clk)
  begin
    tcnt <= tcnt + 1;
    if (tcnt == 20000)
    begin
      n_fail++;
      close_out();
    end
  end
  initial
  begin
    fwd <= 1'b1;
    cyc(5);
    rst_n <= 1'b1;
    rd(ADDR_SEARCH, 32'hFFFFFF, 32'h64, "search reset");
    xf(1'b0, 8'h34, 32'h0);
    ck("slverr", 1, rerr);
    cyc(20);
    ck("no autostart", 0, run_out);
    rerun();
    ck("run", 1, run_out);
    ck("no dwell", 0, dwell_active);
    xf(1'b1, ADDR_DWELL, 32'h0003_0123);
    rerun();
    ck("dwell freq", 32'h0123, freq_cmd);
    cyc(40);
    ck("dwell over", 0, dwell_active);
    xf(1'b1, ADDR_DWELL, 32'h0);
    ref_freq <= 16'h0150;
    for (int i = 0; i < 3; i++)
    begin
      xf(1'b1, ADDR_JUMP0 + 8'(4 * i), 32'h0200_0100);
      cyc(5);
      ck("band", 32'h0100, freq_cmd);
      xf(1'b1, ADDR_JUMP0 + 8'(4 * i), 32'h0);
    end
    xf(1'b1, ADDR_JUMP1, 32'h0200_0100);
    ramp_state <= RAMP_ACCEL;
    cyc(5);
    ck("sweep", 32'h0150, freq_cmd);
    ramp_state <= RAMP_STEADY;
    xf(1'b1, ADDR_CTRL, 32'h1);
    trip(10);
    ck("in phase off", 0, tripped);
    xf(1'b1, ADDR_CTRL, 32'h3);
    @(posedge clk) fault_in <= 12'h011;
    cyc(30);
    ck("priority", FLT_OVERCURRENT, fault_code);
    ck("no retries", 1, tripped);
    fault_in <= 12'h000;
    rd(ADDR_STATUS, 32'h7000, 32'h0, "pending");
    xf(1'b1, ADDR_CMD, 32'h2);
    rd(ADDR_HIST_A, 32'hF, 32'h1, "hist type");
    foreach (codes[i])
    begin
      trip(codes[i] - 1);
      xf(1'b1, ADDR_CMD, 32'h2);
    end
    rd(ADDR_STATUS, 32'h7000, 32'h5000, "count");
    xf(1'b1, ADDR_HIST_SEL, 32'h4);
    rd(ADDR_HIST_A, 32'hF, 32'h5, "oldest");
    xf(1'b1, ADDR_CMD, 32'h1);
    rd(ADDR_STATUS, 32'h7000, 32'h0, "erased");
    xf(1'b1, ADDR_RETRY, 32'h0002_0002);
    rerun();
    trip(0);
    ck("retry dec", 2'd1, retry_left);
    ck("delay", 1, tripped);
    cyc(40);
    ck("auto run", 1, run_out);
    cyc(80);
    ck("credit", 2'd2, retry_left);
    trip(3);
    cyc(40);
    ck("no uv retry", 1, tripped);
    xf(1'b1, ADDR_CTRL, 32'hB);
    @(posedge clk) rterm <= 1'b1;
    cyc(5);
    ck("reset restart", 1, run_out);
    trip(8);
    xf(1'b1, ADDR_CMD, 32'h2);
    cyc(10);
    ck("hw latch", FLT_HARDWARE, fault_code);
    close_out();
  end
endmodule : dfrs_supervisor_tb
`default_nettype wire
